//--- src/itairq_consts.vh
// Register offsets, field positions, reset values, selector codes and table depth of the indirect access block
`ifndef ITAIRQ_CONSTS_VH
`define ITAIRQ_CONSTS_VH
`define ITA_OFS_CTRL0        8'h6E
`define ITA_OFS_CTRL1        8'h6F
`define ITA_OFS_DATA8        8'h70
`define ITA_OFS_DATA7        8'h71
`define ITA_OFS_DATA6        8'h72
`define ITA_OFS_DATA5        8'h73
`define ITA_OFS_DATA4        8'h74
`define ITA_OFS_DATA3        8'h75
`define ITA_OFS_DATA2        8'h76
`define ITA_OFS_DATA1        8'h77
`define ITA_OFS_DATA0        8'h78
`define ITA_OFS_IRQ_STATUS   8'h7C
`define ITA_OFS_IRQ_MASK     8'h7D
`define ITA_CTRL0_DIR_BIT    4
`define ITA_CTRL0_SEL_HI     3
`define ITA_CTRL0_SEL_LO     2
`define ITA_CTRL0_ADDR_HI    1
`define ITA_CTRL0_ADDR_LO    0
`define ITA_PORT1_BIT        1
`define ITA_PORT2_BIT        2
`define ITA_RST_BYTE         8'h00
`define ITA_RST_DATA         69'h0
`define ITA_SEL_STATIC       2'h0
`define ITA_SEL_VLAN         2'h1
`define ITA_SEL_DYNAMIC      2'h2
`define ITA_SEL_MIB          2'h3
`define ITA_TABLE_DEPTH      1024
`endif

//--- src/itairq_indirect_access.v
// Indirect table access port with link change interrupt status and mask
`timescale 1ns/1ps
`include "itairq_consts.vh"

// The host reaches the block through single byte strobes. A write
// command takes two cycles and a read command three, after which the
// done pulse stands for one cycle. Only the link pins cross into this
// clock; they are synchronised here and filtered before they set a flag.
// Everything else runs on the core clock.
module itairq_indirect_access (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// Register port from the host interface logic
	input  wire        regWrEn,
	input  wire        regRdEn,
	input  wire [7:0]  regAddr,
	input  wire [7:0]  regWrData,
	// Read return to the host interface logic
	output reg  [7:0]  regRdData,
	output reg         regRdValid,
	// Link state of the two PHY ports, asynchronous
	input  wire        port1LinkUp,
	input  wire        port2LinkUp,
	// Interrupt request to the host
	output reg         irqReq,
	// Command done pulse
	output reg         cmdDone
);

	// Control registers
	reg  [7:0]  ctrl0_r;                        // Direction, selector, address high
	reg  [7:0]  ctrl1_r;                        // Address low
	reg  [68:0] dataWin_r;                      // Indirect data window
	// Interrupt flags and mask
	reg  [7:0]  irqStatus_r;                    // Sticky link change flags
	reg  [7:0]  irqMask_r;                      // Mask bits
	// Command pipeline; the host waits for the done pulse before the next command
	reg         cmdPend_r;                      // Command taken, memory access next
	reg         rdLoad_r;                       // Read data lands in the window next
	reg  [68:0] memRd_r;                        // Registered memory read word
	// Link synchronisers, three stages; stage zero may go metastable
	reg  [2:0]  p1Sync_r;                       // Port 1 link level, oldest in bit 2
	reg  [2:0]  p2Sync_r;                       // Port 2 link level, oldest in bit 2
	// Last settled link levels, compared against the synchroniser output
	reg         p1Lvl_r;                        // Port 1 settled level
	reg         p2Lvl_r;                        // Port 2 settled level
	// The four stores
	// Each holds 1024 entries of 69 bits; only the selected one is touched
	reg  [68:0] staticMem  [0:`ITA_TABLE_DEPTH-1];
	reg  [68:0] vlanMem    [0:`ITA_TABLE_DEPTH-1];
	reg  [68:0] dynMem     [0:`ITA_TABLE_DEPTH-1];
	reg  [68:0] mibMem     [0:`ITA_TABLE_DEPTH-1];

	// True when the host writes the given offset in this cycle
	function wrHit;
		input       en;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			wrHit = en && (addr == ofs);
		end
	endfunction

	// Derived command fields
	wire [9:0]  cmdAddr  = {ctrl0_r[`ITA_CTRL0_ADDR_HI:`ITA_CTRL0_ADDR_LO], ctrl1_r};
	wire [1:0]  cmdSel   = ctrl0_r[`ITA_CTRL0_SEL_HI:`ITA_CTRL0_SEL_LO];
	wire        cmdRead  = ctrl0_r[`ITA_CTRL0_DIR_BIT];
	wire        wrCtrl1  = wrHit(regWrEn, regAddr, `ITA_OFS_CTRL1);
	// A level counts once stages two and three agree on it; a one cycle
	// glitch never stands in both at once, so it cannot raise a flag
	wire        p1Settled = (p1Sync_r[1] == p1Sync_r[2]);
	wire        p2Settled = (p2Sync_r[1] == p2Sync_r[2]);
	// A settled level that differs from the last one is a link change
	wire        p1Change  = p1Settled && (p1Sync_r[2] != p1Lvl_r);
	wire        p2Change  = p2Settled && (p2Sync_r[2] != p2Lvl_r);
	// A one written to a port's status bit clears that flag
	wire        irqClr1  = wrHit(regWrEn, regAddr, `ITA_OFS_IRQ_STATUS) && regWrData[`ITA_PORT1_BIT];
	wire        irqClr2  = wrHit(regWrEn, regAddr, `ITA_OFS_IRQ_STATUS) && regWrData[`ITA_PORT2_BIT];

	// Byte lane of the data window for an offset in the data range.
	// The top register carries only five data bits; its upper three
	// bits read as zero, since no store holds them
	function [7:0] winByte;
		input [68:0] win;
		input [7:0]  ofs;
		reg   [3:0]  idx;
		begin
			idx = ofs[3:0] - 4'h0;
			case (idx)
				4'h0: winByte = {3'h0, win[68:64]};
				4'h1: winByte = win[63:56];
				4'h2: winByte = win[55:48];
				4'h3: winByte = win[47:40];
				4'h4: winByte = win[39:32];
				4'h5: winByte = win[31:24];
				4'h6: winByte = win[23:16];
				4'h7: winByte = win[15:8];
				4'h8: winByte = win[7:0];
				default: winByte = 8'h00;
			endcase
		end
	endfunction

	// Link input synchronisers. The link pins are not tied to this clock,
	// so they pass two flip-flops before any logic looks at them; the change check also uses the third
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			p1Sync_r <= 3'h0;
			p2Sync_r <= 3'h0;
		end else begin
			p1Sync_r <= {p1Sync_r[1:0], port1LinkUp};
			p2Sync_r <= {p2Sync_r[1:0], port2LinkUp};
		end
	end

	// Settled link levels. They reset to the idle low level, so a link
	// that is already up when reset ends is reported once as a change
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			p1Lvl_r <= 1'b0;
			p2Lvl_r <= 1'b0;
		end else begin
			if (p1Change) begin
				p1Lvl_r <= p1Sync_r[2];             // Follow the new port 1 level
			end
			if (p2Change) begin
				p2Lvl_r <= p2Sync_r[2];             // Follow the new port 2 level
			end
		end
	end

	// Store access, one cycle after the command is taken.
	// The stores have no reset: entries read as unknown until written
	always @(posedge sys_clk) begin
		// Only the cycle after a command start touches a store
		if (cmdPend_r) begin
			// Direction one reads the entry into a holding register
			if (cmdRead) begin
				case (cmdSel)
					`ITA_SEL_STATIC:  memRd_r <= staticMem[cmdAddr];
					`ITA_SEL_VLAN:    memRd_r <= vlanMem[cmdAddr];
					`ITA_SEL_DYNAMIC: memRd_r <= dynMem[cmdAddr];
					default:          memRd_r <= mibMem[cmdAddr];
				endcase
			end else begin
				// Write stores the window into the selected entry
				case (cmdSel)
					`ITA_SEL_STATIC:  staticMem[cmdAddr] <= dataWin_r;
					`ITA_SEL_VLAN:    vlanMem[cmdAddr]   <= dataWin_r;
					`ITA_SEL_DYNAMIC: dynMem[cmdAddr]    <= dataWin_r;
					default:          mibMem[cmdAddr]    <= dataWin_r;
				endcase
			end
		end
	end

	// Command sequencing. A write to the low address byte starts a command;
	// the store is reached one cycle later, so the address and direction
	// written just before it are already in place
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmdPend_r <= 1'b0;
			rdLoad_r  <= 1'b0;
			cmdDone   <= 1'b0;
		end else begin
			cmdPend_r <= wrCtrl1;               // Only this offset starts a command
			rdLoad_r  <= cmdPend_r && cmdRead;  // Read word lands one cycle later
			// Write finishes with the store update, read with the window load
			cmdDone   <= (cmdPend_r && !cmdRead) || rdLoad_r;
		end
	end

	// Control registers: direction, selector and the ten bit address
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl0_r <= `ITA_RST_BYTE;
			ctrl1_r <= `ITA_RST_BYTE;
		end else begin
			if (regWrEn) begin
				case (regAddr)
					`ITA_OFS_CTRL0: ctrl0_r <= regWrData;   // Direction, selector, address high
					`ITA_OFS_CTRL1: ctrl1_r <= regWrData;   // Address low
					default: ;                          // Other offsets leave them alone
				endcase
			end
		end
	end

	// Data window. A read command loads it first; a host write in the same
	// cycle lands on top, so the host must not write it during a command
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dataWin_r <= `ITA_RST_DATA;
		end else begin
			if (rdLoad_r) begin
				dataWin_r <= memRd_r;           // Entry read from the store
			end
			if (regWrEn) begin
				// Lane order runs from the top bits down
				case (regAddr)
					`ITA_OFS_DATA8: dataWin_r[68:64] <= regWrData[4:0]; // Only five bits exist
					`ITA_OFS_DATA7: dataWin_r[63:56] <= regWrData;
					`ITA_OFS_DATA6: dataWin_r[55:48] <= regWrData;
					`ITA_OFS_DATA5: dataWin_r[47:40] <= regWrData;
					`ITA_OFS_DATA4: dataWin_r[39:32] <= regWrData;
					`ITA_OFS_DATA3: dataWin_r[31:24] <= regWrData;
					`ITA_OFS_DATA2: dataWin_r[23:16] <= regWrData;
					`ITA_OFS_DATA1: dataWin_r[15:8]  <= regWrData;
					`ITA_OFS_DATA0: dataWin_r[7:0]   <= regWrData;
					default: ;                      // Not a window byte
				endcase
			end
		end
	end

	// Mask register; only the two port bits exist, the rest read zero
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irqMask_r <= `ITA_RST_BYTE;
		end else begin
			if (wrHit(regWrEn, regAddr, `ITA_OFS_IRQ_MASK)) begin
				irqMask_r[`ITA_PORT2_BIT] <= regWrData[`ITA_PORT2_BIT];   // Port 2 mask
				irqMask_r[`ITA_PORT1_BIT] <= regWrData[`ITA_PORT1_BIT];   // Port 1 mask
			end
		end
	end

	// Sticky interrupt flags; a new event wins over a clear in the same
	// cycle, so a change that races the host's clear is never lost.
	// Reserved bits are never written and stay zero
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irqStatus_r <= `ITA_RST_BYTE;
		end else begin
			// Port 2 flag
			if (p2Change) begin
				irqStatus_r[`ITA_PORT2_BIT] <= 1'b1;
			end else if (irqClr2) begin
				irqStatus_r[`ITA_PORT2_BIT] <= 1'b0;
			end
			// Port 1 flag
			if (p1Change) begin
				irqStatus_r[`ITA_PORT1_BIT] <= 1'b1;
			end else if (irqClr1) begin
				irqStatus_r[`ITA_PORT1_BIT] <= 1'b0;
			end
		end
	end

	// Interrupt request from unmasked flags. It is registered so that the
	// output comes from a flip-flop; it follows a flag by one cycle
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irqReq <= 1'b0;
		end else begin
			irqReq <= (irqStatus_r[`ITA_PORT2_BIT] && !irqMask_r[`ITA_PORT2_BIT])
				|| (irqStatus_r[`ITA_PORT1_BIT] && !irqMask_r[`ITA_PORT1_BIT]);
		end
	end

	// Register read port, answer one cycle after the strobe.
	// Read data holds until the next read; reserved and unmapped places
	// read zero, and a read never changes any state
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			regRdData  <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			// Data is taken only on a strobe; otherwise the last value holds
			if (regRdEn) begin
				if (regAddr == `ITA_OFS_CTRL0) begin
					regRdData <= ctrl0_r;
				end else if (regAddr == `ITA_OFS_CTRL1) begin
					regRdData <= ctrl1_r;
				end else if (regAddr >= `ITA_OFS_DATA8 && regAddr <= `ITA_OFS_DATA0) begin
					regRdData <= winByte(dataWin_r, regAddr);
				end else if (regAddr == `ITA_OFS_IRQ_STATUS) begin
					regRdData <= irqStatus_r;
				end else if (regAddr == `ITA_OFS_IRQ_MASK) begin
					regRdData <= irqMask_r;
				end else begin
					regRdData <= 8'h00;
				end
			end
		end
	end

endmodule // itairq_indirect_access

//--- dv/itairq_host_model.sv
// Host side register access model for the indirect access block
`timescale 1ns/1ps
module itairq_host_model (
	// Clock and read return
	input  wire       sys_clk,
	input  wire [7:0] regRdData,
	input  wire       regRdValid,
	// Register strobes
	output reg        regWrEn,
	output reg        regRdEn,
	output reg  [7:0] regAddr,
	output reg  [7:0] regWrData
);
	initial begin
		{regWrEn, regRdEn, regAddr, regWrData} = 18'h0;
	end
	// One write; released lines show inverted values
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge sys_clk);
			{regWrEn, regAddr, regWrData} = {1'b1, a, d};
			@(negedge sys_clk);
			{regWrEn, regAddr, regWrData} = {1'b0, ~a, ~d};
		end
	endtask
	// One read; data taken while the valid pulse stands
	task rd(input [7:0] a, output [7:0] q);
		begin
			@(negedge sys_clk);
			{regRdEn, regAddr} = {1'b1, a};
			@(negedge sys_clk);
			regRdEn = 1'b0;
			q = regRdData;
		end
	endtask
endmodule // itairq_host_model

//--- dv/itairq_asserts.sv
// Port level assertions for the indirect access block
`timescale 1ns/1ps
module itairq_asserts (
	// Clock, reset and register port
	input wire       sys_clk,
	input wire       rstn,
	input wire       regWrEn,
	input wire       regRdEn,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire [7:0] regRdData,
	input wire       regRdValid,
	// Links and events
	input wire       port1LinkUp,
	input wire       port2LinkUp,
	input wire       irqReq,
	input wire       cmdDone
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire go = regWrEn && regAddr == 8'h6F;
	rd_valid_a: assert property (regRdEn |=> regRdValid) else $error("read valid missing");
	valid_src_a: assert property (regRdValid |-> $past(regRdEn)) else $error("stray read valid");
	cmd_done_a: assert property (go |-> ##[2:3] cmdDone) else $error("command not done");
	done_src_a: assert property (cmdDone |-> $past(go, 2) || $past(go, 3)) else $error("stray done");
	done_pulse_a: assert property (cmdDone |=> !cmdDone) else $error("done too long");
	data_top_a: assert property (regRdEn && regAddr == 8'h70 |=> regRdData[7:5] == 3'h0)
		else $error("window top bits set");
	stat_resv_a: assert property (regRdEn && regAddr == 8'h7C |=> (regRdData & 8'hF9) == 8'h00)
		else $error("status reserved set");
	mask_resv_a: assert property (regRdEn && regAddr == 8'h7D |=> (regRdData & 8'hF9) == 8'h00)
		else $error("mask reserved set");
endmodule // itairq_asserts
bind itairq_indirect_access itairq_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn), .regWrEn(regWrEn),
	.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
	.regRdValid(regRdValid), .port1LinkUp(port1LinkUp), .port2LinkUp(port2LinkUp),
	.irqReq(irqReq), .cmdDone(cmdDone));

//--- dv/tb.sv
// Self-checking bench for the indirect access block
`timescale 1ns/1ps
module tb;
	reg        sys_clk, rstn, port1LinkUp, port2LinkUp;
	wire       regWrEn, regRdEn, regRdValid, irqReq, cmdDone;
	wire [7:0] regAddr, regWrData, regRdData;
	reg  [7:0] q;
	integer    error_cnt = 0, check_count = 0;
	integer    doneCnt = 0;
	itairq_host_model HOST (.sys_clk(sys_clk), .regRdData(regRdData), .regRdValid(regRdValid),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
	itairq_indirect_access DUT (.sys_clk(sys_clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
		.port1LinkUp(port1LinkUp), .port2LinkUp(port2LinkUp), .irqReq(irqReq), .cmdDone(cmdDone));
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Count every done pulse the design gives
	always @(posedge sys_clk)
		if (cmdDone === 1'b1)
			doneCnt <= doneCnt + 1;
	task chk(input [7:0] got, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			HOST.rd(a, q);
			chk(q, e);
		end
	endtask
	// Launch a command and wait a bounded time for its done pulse
	task launch(input [7:0] a);
		reg d;
		integer n;
		begin
			d = 0;
			n = doneCnt;
			HOST.wr(8'h6F, a);
			repeat (4) begin
				@(posedge sys_clk);
				#1 d = d | cmdDone;
			end
			chk({7'h0, d}, 8'h01);
			chk(doneCnt[7:0] - n[7:0], 8'h01);
		end
	endtask
	// Writes to other offsets start no command and leave the window alone
	task t_quiet;
		integer n;
		begin
			n = doneCnt;
			HOST.wr(8'h6E, 8'h10);
			HOST.wr(8'h78, 8'h5A);
			repeat (6) @(posedge sys_clk);
			#1 chk(doneCnt[7:0] - n[7:0], 8'h00);
			rc(8'h78, 8'h5A);
			$display("quiet test done");
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", check_count, error_cnt);
			if (error_cnt == 0 && check_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// Reset values, unmapped places read zero
	task t_reset;
		integer a;
		begin
			for (a = 8'h6E; a < 8'h7E; a = a + 1)
				rc(a[7:0], 8'h00);
			$display("reset test done");
		end
	endtask
	// Fill all four stores at one address, then read each back
	task t_table;
		integer s, i;
		begin
			for (s = 0; s < 4; s = s + 1) begin
				HOST.wr(8'h6E, {4'h0, s[1:0], 2'h3});
				for (i = 0; i < 9; i = i + 1)
					HOST.wr(8'h70 + i, 8'h11 * i + s);
				launch(8'hA5);
			end
			for (s = 0; s < 4; s = s + 1) begin
				for (i = 0; i < 9; i = i + 1)
					HOST.wr(8'h70 + i, 8'h00);
				HOST.wr(8'h6E, {4'h1, s[1:0], 2'h3});
				launch(8'hA5);
				for (i = 0; i < 9; i = i + 1)
					rc(8'h70 + i, (8'h11 * i + s) & (i ? 8'hFF : 8'h1F));
			end
			rc(8'h6E, 8'h1F);
			rc(8'h6F, 8'hA5);
			$display("table test done");
		end
	endtask
	// Link change, mask, write-zero and write-one clear
	task t_irq(input integer p);
		reg [7:0] b;
		begin
			b = 8'h01 << p;
			@(negedge sys_clk);
			if (p == 1)
				port1LinkUp = ~port1LinkUp;
			else
				port2LinkUp = ~port2LinkUp;
			repeat (8) @(negedge sys_clk);
			rc(8'h7C, b);
			chk({7'h0, irqReq}, 8'h01);
			HOST.wr(8'h7D, b);
			repeat (2) @(negedge sys_clk);
			chk({7'h0, irqReq}, 8'h00);
			rc(8'h7D, b);
			HOST.wr(8'h7D, 8'h00);
			repeat (2) @(negedge sys_clk);
			chk({7'h0, irqReq}, 8'h01);
			HOST.wr(8'h7C, ~b);
			rc(8'h7C, b);
			HOST.wr(8'h7C, b);
			rc(8'h7C, 8'h00);
			chk({7'h0, irqReq}, 8'h00);
			$display("link test done");
		end
	endtask
	initial begin
		rstn = 0;
		port1LinkUp = 0;
		port2LinkUp = 0;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk) rstn = 1;
		t_reset;
		t_quiet;
		t_table;
		t_irq(1);
		t_irq(2);
		print_verdict;
	end
	initial begin
		#50000;
		error_cnt = error_cnt + 1;
		print_verdict;
	end
endmodule // tb
